//--- design/acw_pkg.sv
// acw_pkg: constants, types and field layout for the analog combo io word interface
// assumes one 100 MHz clock; the scan strobe comes from the backplane logic
//
// Contract
// - sixteen input points, sixteen output points
// - input bits 11..0 unsigned conversion value
// - output bits 11..0 unsigned value to convert
// - indicator bits give active channel minus one
// - one enabled channel per scan, wrap
// - each output channel whose select is low is transferred per scan, both at once when both selects are low
// - busy set on first scan
// - busy set on noise after first scan
// - pointer mode busy reported as 8000
// - failure bit set when not operating
// - data reads zero during failure
// - failure module-wide, clears by itself
// - active-low selects choose output channels
// - counts span 0 through 4095
package acw_pkg;
    localparam int          ACW_WORD_W   = 16;
    localparam int          ACW_DATA_W   = 12;
    localparam int          ACW_NUM_IN   = 4;
    localparam int          ACW_NUM_OUT  = 2;
    localparam int          ACW_CODE_W   = 2;
    localparam logic [11:0] ACW_FULL_CNT = 12'hFFF;
    localparam logic [11:0] ACW_ZERO_CNT = 12'h000;
    localparam logic [15:0] ACW_PTR_BUSY = 16'h8000;
    localparam logic [1:0]  ACW_CODE_CH1 = 2'h0;

    // input word to the cpu, msb first
    typedef struct packed {
        logic        fail;
        logic        busy;
        logic [1:0]  chan;
        logic [11:0] data;
    } acw_in_word_type;

    // output word from the cpu, msb first; selects are active low
    typedef struct packed {
        logic [1:0]  spare;
        logic        ch2_select_n;
        logic        ch1_select_n;
        logic [11:0] data;
    } acw_out_word_type;
endpackage : acw_pkg

//--- design/acw_chan_seq.sv
// acw_chan_seq: picks the next enabled input channel each scan
// assumes scan_i is a one-cycle strobe synchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module acw_chan_seq
    import acw_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  scan_i,
    input  wire logic [ACW_NUM_IN-1:0] chan_en_i,
    output logic      [ACW_CODE_W-1:0] chan_o
);
    logic [ACW_CODE_W-1:0] chan_q;
    logic [ACW_CODE_W-1:0] chan_d;
    logic [ACW_CODE_W-1:0] cand   [ACW_NUM_IN];
    logic [ACW_NUM_IN-1:0] hit;

    // candidates in wrap order after the current channel
    genvar g;
    generate
        for (g = 0; g < ACW_NUM_IN; g++) begin : g_cand
            assign cand[g] = ACW_CODE_W'(chan_q + ACW_CODE_W'(g + 1));
            assign hit[g]  = chan_en_i[cand[g]];
        end
    endgenerate

    always_comb begin
        chan_d = ACW_CODE_CH1;
        for (int i = ACW_NUM_IN - 1; i >= 0; i--) begin
            if (hit[i]) begin
                chan_d = cand[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chan_q <= ACW_CODE_CH1;
        end else if (clk_en_i && scan_i) begin
            chan_q <= chan_d;
        end
    end

    assign chan_o = chan_q;
endmodule // acw_chan_seq
`default_nettype wire

//--- design/acw_out_latch.sv
// acw_out_latch: holds the two output channel values
// assumes the cpu word is stable when scan_i pulses
`timescale 1ns/1ps
`default_nettype none
module acw_out_latch
    import acw_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  scan_i,
    input  wire acw_out_word_type      word_i,
    output logic      [ACW_DATA_W-1:0] out_ch1_o,
    output logic      [ACW_DATA_W-1:0] out_ch2_o
);
    logic [ACW_DATA_W-1:0] ch_q [ACW_NUM_OUT];
    logic [ACW_NUM_OUT-1:0] sel_n;

    assign sel_n = {word_i.ch2_select_n, word_i.ch1_select_n};

    // each low select loads its channel; both high holds both
    // only this scan's word is taken
    genvar g;
    generate
        for (g = 0; g < ACW_NUM_OUT; g++) begin : g_ch
            always_ff @(posedge sys_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    ch_q[g] <= ACW_ZERO_CNT;
                end else if (clk_en_i && scan_i && !sel_n[g]) begin
                    ch_q[g] <= word_i.data;
                end
            end
        end
    endgenerate

    assign out_ch1_o = ch_q[0];
    assign out_ch2_o = ch_q[1];
endmodule // acw_out_latch
`default_nettype wire

//--- design/acw_io_word.sv
// acw_io_word: backplane word interface of the combo analog module
// assumes scan_strobe_i marks one cpu scan, conversion results arrive per channel
`timescale 1ns/1ps
`default_nettype none
module acw_io_word
    import acw_pkg::*;
(
    input  wire logic                             sys_clk_i,
    input  wire logic                             resetn_i,
    input  wire logic                             clk_en_i,
    input  wire logic                             scan_strobe_i,
    input  wire logic                             pointer_mode_i,
    input  wire logic [ACW_NUM_IN-1:0]            chan_en_i,
    input  wire logic [ACW_NUM_IN*ACW_DATA_W-1:0] adc_data_i,
    input  wire logic                             noise_det_i,
    input  wire logic                             module_fault_i,
    input  wire acw_out_word_type                 out_word_i,
    output acw_in_word_type                       in_word_o,
    output logic      [ACW_WORD_W-1:0]            ptr_word_o,
    output logic      [ACW_DATA_W-1:0]            dac_ch1_o,
    output logic      [ACW_DATA_W-1:0]            dac_ch2_o,
    output logic                                  first_scan_o
);
    logic                  first_q;
    logic [ACW_CODE_W-1:0] chan;
    logic [ACW_DATA_W-1:0] sel_data;
    logic                  busy;
    acw_in_word_type       word_d;
    acw_in_word_type       word_q;
    logic [ACW_WORD_W-1:0] ptr_d;
    logic [ACW_WORD_W-1:0] ptr_q;

    acw_chan_seq u_seq (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .scan_i    (scan_strobe_i),
        .chan_en_i (chan_en_i),
        .chan_o    (chan)
    );

    acw_out_latch u_out (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .scan_i    (scan_strobe_i),
        .word_i    (out_word_i),
        .out_ch1_o (dac_ch1_o),
        .out_ch2_o (dac_ch2_o)
    );

    // pick the active channel's 12-bit count
    assign sel_data = adc_data_i[chan*ACW_DATA_W +: ACW_DATA_W];

    // busy on the first scan or on noise
    assign busy = first_q || noise_det_i;

    // assemble the word; fault flag and zeroed data
    always_comb begin
        word_d.fail = module_fault_i;
        word_d.busy = busy;
        word_d.chan = chan;
        word_d.data = module_fault_i ? ACW_ZERO_CNT : sel_data;
    end

    // pointer transfers carry busy as 8000 instead of a flag
    assign ptr_d = busy ? ACW_PTR_BUSY : {{(ACW_WORD_W-ACW_DATA_W){1'b0}}, word_d.data};

    // first-scan flag drops after the first completed scan
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            first_q <= 1'b1;
        end else if (clk_en_i && scan_strobe_i) begin
            first_q <= 1'b0;
        end
    end

    // words update each cycle that clk_en_i is high; the cpu samples at its scan
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_q <= '0;
            ptr_q  <= '0;
        end else if (clk_en_i) begin
            word_q <= word_d;
            ptr_q  <= pointer_mode_i ? ptr_d : '0;
        end
    end

    assign in_word_o    = word_q;
    assign ptr_word_o   = ptr_q;
    assign first_scan_o = first_q;

    // busy must show while the first scan is pending
    first_busy_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && first_q) |=> word_q.busy) else $error("busy missing on first scan");
    noise_busy_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && noise_det_i) |=> word_q.busy) else $error("busy missing on noise");
    fail_zero_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && module_fault_i) |=> (word_q.fail && word_q.data == ACW_ZERO_CNT))
        else $error("fault must zero data");
    fail_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && !module_fault_i) |=> !word_q.fail) else $error("fail did not clear");
    ptr_busy_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && pointer_mode_i && busy) |=> ptr_q == ACW_PTR_BUSY)
        else $error("pointer busy value wrong");
    chan_code_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i |=> word_q.chan == $past(chan)) else $error("channel code mismatch");
    chan_enabled_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && scan_strobe_i && chan_en_i == 4'hF) |=> chan == ACW_CODE_W'($past(chan) + 2'h1))
        else $error("channel did not step");
    hold_none_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && scan_strobe_i && out_word_i.ch1_select_n && out_word_i.ch2_select_n)
        |=> $stable(dac_ch1_o) && $stable(dac_ch2_o)) else $error("outputs changed unselected");
    load_both_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && scan_strobe_i && !out_word_i.ch1_select_n && !out_word_i.ch2_select_n)
        |=> dac_ch1_o == $past(out_word_i.data) && dac_ch2_o == $past(out_word_i.data))
        else $error("both channels not loaded");

    scan_cov_c:  cover property (@(posedge sys_clk_i) clk_en_i && scan_strobe_i && !first_q);
    fault_cov_c: cover property (@(posedge sys_clk_i) clk_en_i && module_fault_i);
    wrap_cov_c:  cover property (@(posedge sys_clk_i) scan_strobe_i && chan == 2'h3);
    ptr_cov_c:   cover property (@(posedge sys_clk_i) pointer_mode_i && noise_det_i);
endmodule // acw_io_word
`default_nettype wire

//--- tb/acw_cpu_model.sv
// acw_cpu_model: controller side, one scan strobe and one output word per request
// assumes the bench raises scan_req_i for each scan it wants
`timescale 1ns/1ps
`default_nettype none
module acw_cpu_model
    import acw_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             scan_req_i,
    input  wire acw_out_word_type word_i,
    output logic                  scan_strobe_o,
    output var acw_out_word_type  out_word_o
);
    // idle word keeps both selects high so a stray strobe updates nothing
    // one word per scan
    // words arrive already scaled to counts 0..4095
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scan_strobe_o <= 1'b0;
            out_word_o    <= 16'hFFFF;
        end else begin
            scan_strobe_o <= scan_req_i;
            if (scan_req_i) out_word_o <= word_i;
        end
    end
endmodule // acw_cpu_model
`default_nettype wire

//--- tb/acw_io_word_tb_top.sv
// acw_io_word_tb_top: self-checking bench for the backplane word interface
// assumes acw_pkg, acw_io_word and acw_cpu_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module acw_io_word_tb_top
    import acw_pkg::*;
;
    typedef struct packed {
        logic [3:0]  en;
        logic [15:0] ow;
        logic [2:0]  nfp;
        logic [15:0] ein;
        logic [15:0] eptr;
        logic [11:0] d1;
        logic [11:0] d2;
    } acw_row_type;
    logic             sys_clk_i, resetn_i, clk_en_i, scan_req, scan_strobe, first_scan;
    logic             pointer_mode_i, noise_det_i, module_fault_i;
    logic [3:0]       chan_en_i;
    logic [15:0]      ptr_word;
    logic [11:0]      dac1, dac2;
    acw_out_word_type cpu_word, out_word;
    acw_in_word_type  in_word;
    int               mismatches, check_count;
    acw_row_type      rows [6];
    // counts of channels 1..4; 800 and FFF reach the top data bit
    localparam logic [47:0] ADC = {12'hFFF, 12'h7FE, 12'h800, 12'h001};

    acw_cpu_model cpu (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scan_req_i(scan_req), .word_i(cpu_word),
        .scan_strobe_o(scan_strobe), .out_word_o(out_word));
    acw_io_word uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i), .scan_strobe_i(scan_strobe),
        .pointer_mode_i(pointer_mode_i), .chan_en_i(chan_en_i), .adc_data_i(ADC), .noise_det_i(noise_det_i),
        .module_fault_i(module_fault_i), .out_word_i(out_word), .in_word_o(in_word), .ptr_word_o(ptr_word),
        .dac_ch1_o(dac1), .dac_ch2_o(dac2), .first_scan_o(first_scan));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // called at an edge; settles long enough for the channel change to show
    task automatic scan(input int n);
        scan_req <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        scan_req <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic do_reset();
        resetn_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        #1;
        check("in_word", in_word, 16'h0000);
        check("first_scan", {15'h0, first_scan}, 16'h0001);
        check("dac1", {4'h0, dac1}, 16'h0000);
        @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        check("busy_first", in_word, 16'h4001);
        @(posedge sys_clk_i);
    endtask

    // free-running 100 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // rows: enables, cpu word, noise/fault/pointer, expected words and dac values
    initial begin
        {resetn_i, clk_en_i, scan_req, pointer_mode_i, noise_det_i, module_fault_i} = 6'b010000;
        chan_en_i = 4'hF;
        cpu_word = 16'hFFFF;
        mismatches = 0;
        check_count = 0;
        rows = '{{4'hF, 16'h05A5, 3'h0, 16'h1800, 16'h0000, 12'h5A5, 12'h5A5},
                 {4'hF, 16'h2FFF, 3'h1, 16'h27FE, 16'h07FE, 12'hFFF, 12'h5A5},
                 {4'hF, 16'h1000, 3'h5, 16'h7FFF, 16'h8000, 12'hFFF, 12'h000},
                 {4'hF, 16'h3123, 3'h3, 16'h8000, 16'h0000, 12'hFFF, 12'h000},
                 {4'h5, 16'h2800, 3'h0, 16'h27FE, 16'h0000, 12'h800, 12'h000},
                 {4'h5, 16'hF000, 3'h1, 16'h0001, 16'h0001, 12'h800, 12'h000}};
        do_reset();
        foreach (rows[i]) begin
            chan_en_i <= rows[i].en;
            cpu_word <= rows[i].ow;
            {noise_det_i, module_fault_i, pointer_mode_i} <= rows[i].nfp;
            scan(1);
            check("in_word", in_word, rows[i].ein);
            check("ptr_word", ptr_word, rows[i].eptr);
            check("dac1", {4'h0, dac1}, {4'h0, rows[i].d1});
            check("dac2", {4'h0, dac2}, {4'h0, rows[i].d2});
            check("first_scan", {15'h0, first_scan}, 16'h0000);
            @(posedge sys_clk_i);
        end
        // back-to-back strobes walk channel 1 to channel 3
        chan_en_i <= 4'hF;
        pointer_mode_i <= 1'b0;
        scan(2);
        check("in_word", in_word, 16'h27FE);
        @(posedge sys_clk_i);
        // frozen clock enable must ignore a strobe that selects both outputs
        clk_en_i <= 1'b0;
        cpu_word <= 16'h0111;
        scan(1);
        check("dac1", {4'h0, dac1}, 16'h0800);
        check("in_word", in_word, 16'h27FE);
        @(posedge sys_clk_i);
        clk_en_i <= 1'b1;
        do_reset();
        close_out();
    end

    // watchdog, far beyond the roughly 80 cycles the run needs
    initial begin
        #20000;
        mismatches++;
        close_out();
    end
endmodule // acw_io_word_tb_top
`default_nettype wire
